/* File: boundary_scan_tap.sv */
/*
  Boundary-scan test access port: controller, instruction register, bypass,
  identification and boundary registers, and the pin muxing they steer.
  Assumes the tester's test clock is an asynchronous pin sampled here by clk.
*/
// Summary of operation
// RULE1: Sixteen-state controller stepped by test clock, mode select.
// RULE2: One-bit bypass register between data in, out.
// RULE3: Boundary register exactly 256 bits, shifted serially.
// RULE4: Thirty-two bit identification register, captured and shifted.
// RULE5: One boundary cell per pin, single chain; here each pin pair shares one output cell and one enable cell for driving.
// RULE6: Test state independent of system logic activity.
// RULE7: Boundary cells drive and capture pins.
// RULE8: Sample captures live pins without disturbing them.
// RULE9: Bypass shortens path to one bit.
// RULE10: Output disable instruction releases all drivers.
// RULE11: Clamp instruction holds outputs from boundary cells.
// RULE12: Sample on rising edge, data out falls.
// RULE13: Reset via test reset or five mode-high clocks.
`timescale 1ns/1ps
`default_nettype none
`include "tap_params.svh"
module boundary_scan_tap import tap_pkg::*; #(
  parameter int NPINS = `TAP_BSR_LEN,
  parameter logic [31:0] ID_VALUE = `TAP_ID_DEFAULT
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo_o,
  output logic tdo_oe_n,
  input wire logic [NPINS-1:0] sys_out,
  input wire logic [NPINS-1:0] sys_oe_n,
  input wire logic [NPINS-1:0] pin_in,
  output logic [NPINS-1:0] pin_out,
  output logic [NPINS-1:0] pin_oe_n,
  output logic test_mode
);
  // Output cells sit in the even chain slots, enable cells in the odd ones.
  localparam int HALF = NPINS / 2;
  tck_if ev ();
  tap_pin_sync u_sync (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .tck_pin(tck),
    .tms_pin(tms),
    .tdi_pin(tdi),
    .trst_n_pin(trst_n),
    .ev(ev)
  );

  tap_state_t st_q, st_d;
  logic [`TAP_IR_LEN-1:0] ir_q, ir_d, irs_q, irs_d;
  logic byp_q, byp_d;
  logic [`TAP_ID_LEN-1:0] id_q, id_d;
  logic [NPINS-1:0] bsr_q, bsr_d, upd_q, upd_d;
  logic tdo_q, tdo_d, oe_n_q, oe_n_d;
  logic dr_out;

  // RULE1: state transition table
  always_comb begin
    st_d = st_q;
    if (ev.rise) begin
      unique case (st_q)
        ST_RESET: st_d = ev.tms ? ST_RESET : ST_IDLE;
        ST_IDLE: st_d = ev.tms ? ST_SEL_DR : ST_IDLE;
        ST_SEL_DR: st_d = ev.tms ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: st_d = ev.tms ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR: st_d = ev.tms ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: st_d = ev.tms ? ST_UPD_DR : ST_PA_DR;
        ST_PA_DR: st_d = ev.tms ? ST_EX2_DR : ST_PA_DR;
        ST_EX2_DR: st_d = ev.tms ? ST_UPD_DR : ST_SH_DR;
        ST_UPD_DR: st_d = ev.tms ? ST_SEL_DR : ST_IDLE;
        ST_SEL_IR: st_d = ev.tms ? ST_RESET : ST_CAP_IR;
        ST_CAP_IR: st_d = ev.tms ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR: st_d = ev.tms ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: st_d = ev.tms ? ST_UPD_IR : ST_PA_IR;
        ST_PA_IR: st_d = ev.tms ? ST_EX2_IR : ST_PA_IR;
        ST_EX2_IR: st_d = ev.tms ? ST_UPD_IR : ST_SH_IR;
        ST_UPD_IR: st_d = ev.tms ? ST_SEL_DR : ST_IDLE;
        default: st_d = ST_RESET;
      endcase
    end
    // RULE13: asynchronous-style test reset
    if (!ev.trst_n) begin
      st_d = ST_RESET;
    end
  end

  // Instruction register; reset selects the identification register.
  always_comb begin
    ir_d = ir_q;
    irs_d = irs_q;
    if (ev.rise) begin
      if (st_q == ST_CAP_IR) begin
        irs_d = `TAP_IR_CAPTURE;
      end else if (st_q == ST_SH_IR) begin
        irs_d = {ev.tdi, irs_q[`TAP_IR_LEN-1:1]};
      end else if (st_q == ST_UPD_IR) begin
        ir_d = irs_q;
      end
    end
    // RULE13: select identification on reset
    if (st_q == ST_RESET || !ev.trst_n) begin
      ir_d = `TAP_INS_IDCODE;
    end
  end

  // Data registers shift only on test clock edges, never from system clocking.
  always_comb begin
    byp_d = byp_q;
    id_d = id_q;
    bsr_d = bsr_q;
    upd_d = upd_q;
    if (ev.rise) begin
      unique case (st_q)
        ST_CAP_DR: begin
          byp_d = 1'b0;
          id_d = ID_VALUE;
          // RULE7: capture pin levels
          // RULE8: sample live pins
          bsr_d = pin_in;
        end
        ST_SH_DR: begin
          // RULE2: one-bit bypass shift
          byp_d = ev.tdi;
          // RULE4: identification shift
          id_d = {ev.tdi, id_q[`TAP_ID_LEN-1:1]};
          // RULE3: boundary chain shift
          // RULE5: single continuous chain
          bsr_d = {ev.tdi, bsr_q[NPINS-1:1]};
        end
        ST_UPD_DR: begin
          // Clamp leaves the update latch alone so its levels stay put.
          if (ir_q == `TAP_INS_EXTEST || ir_q == `TAP_INS_SAMPLE) begin
            upd_d = bsr_q;
          end
        end
        default: begin
        end
      endcase
    end
    // RULE6: test state only on test reset
    if (!ev.trst_n) begin
      upd_d = '0;
    end
  end

  // RULE9: path shortened to bypass bit
  always_comb begin
    unique case (ir_q)
      `TAP_INS_IDCODE: dr_out = id_q[0];
      `TAP_INS_EXTEST, `TAP_INS_SAMPLE: dr_out = bsr_q[0];
      default: dr_out = byp_q;
    endcase
  end

  // RULE12: data out updates on falling edge
  always_comb begin
    tdo_d = tdo_q;
    oe_n_d = oe_n_q;
    if (ev.fall) begin
      oe_n_d = !(st_q == ST_SH_DR || st_q == ST_SH_IR);
      tdo_d = (st_q == ST_SH_IR) ? irs_q[0] : dr_out;
    end
    // RULE13: test reset releases data out
    if (!ev.trst_n) begin
      oe_n_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= ST_RESET;
      ir_q <= `TAP_INS_IDCODE;
      irs_q <= '0;
      byp_q <= 1'b0;
      id_q <= '0;
      bsr_q <= '0;
      upd_q <= '0;
      tdo_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else if (ce) begin
      st_q <= st_d;
      ir_q <= ir_d;
      irs_q <= irs_d;
      byp_q <= byp_d;
      id_q <= id_d;
      bsr_q <= bsr_d;
      upd_q <= upd_d;
      tdo_q <= tdo_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign tdo_o = tdo_q;
  assign tdo_oe_n = oe_n_q;
  assign test_mode = (ir_q == `TAP_INS_EXTEST) || (ir_q == `TAP_INS_CLAMP)
                     || (ir_q == `TAP_INS_HIGHZ);

  // Pin muxing; sample and bypass leave the system path untouched.
  always_comb begin
    pin_out = sys_out;
    pin_oe_n = sys_oe_n;
    unique case (ir_q)
      // RULE7: cells drive pins
      // RULE11: clamp holds cell levels
      `TAP_INS_EXTEST, `TAP_INS_CLAMP: begin
        for (int i = 0; i < HALF; i++) begin
          pin_out[2*i] = upd_q[2*i];
          pin_out[2*i+1] = upd_q[2*i];
          pin_oe_n[2*i] = upd_q[2*i+1];
          pin_oe_n[2*i+1] = upd_q[2*i+1];
        end
      end
      // RULE10: release all drivers
      `TAP_INS_HIGHZ: pin_oe_n = '1;
      default: begin
      end
    endcase
  end
endmodule
`default_nettype wire

/* File: boundary_scan_tap_asserts.sv */
/* Checker for the test port pins.
   Assumes it is bound to the top module and that nothing drives ce low. */
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_tap_asserts #(parameter int NPINS = 256) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  input wire logic tdo_o,
  input wire logic tdo_oe_n,
  input wire logic [NPINS-1:0] sys_out,
  input wire logic [NPINS-1:0] sys_oe_n,
  input wire logic [NPINS-1:0] pin_in,
  input wire logic [NPINS-1:0] pin_out,
  input wire logic [NPINS-1:0] pin_oe_n,
  input wire logic test_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_tdo_on_fall: assert property ($changed(tdo_o) |-> !$past(tck,2) && !$past(tck,3))
    else $error("data out moved off a clock fall");
  a_oe_on_fall: assert property ($changed(tdo_oe_n) |-> !$past(tck,2) && !$past(tck,3))
    else $error("data out enable moved off a clock fall");
  a_oe_holds_shift: assert property ($fell(tdo_oe_n) |=> !tdo_oe_n [*8])
    else $error("data out enable too short");
  a_reset_values: assert property ($rose(resetn) |-> !test_mode && tdo_oe_n && !tdo_o)
    else $error("bad values after reset");
  a_trst_clears: assert property (!trst_n [*6] |-> !test_mode && tdo_oe_n)
    else $error("test reset ignored");
  a_idle_still: assert property (($stable(tck) && $stable(trst_n)) [*8] |-> $stable(test_mode))
    else $error("test mode moved without test clock");
  a_clamp_frozen: assert property ((test_mode && !(&pin_oe_n) && $stable(tck)) [*8] |-> $stable(pin_out))
    else $error("pins moved in test mode");
  a_normal_pass: assert property (!test_mode |-> pin_out == sys_out && pin_oe_n == sys_oe_n)
    else $error("system pins disturbed");
  c_shift: cover property ($fell(tdo_oe_n));
  c_test_on: cover property ($rose(test_mode));
  c_test_off: cover property ($fell(test_mode));
endmodule
bind boundary_scan_tap boundary_scan_tap_asserts #(.NPINS(NPINS)) boundary_scan_tap_asserts_inst (.*);
`default_nettype wire

/* File: tap_params.svh */
/*
  Constants for the boundary-scan test port: register lengths, instruction codes
  and reset values. Assumes inclusion by bare name from the design files.
*/
`ifndef TAP_PARAMS_SVH
`define TAP_PARAMS_SVH
`define TAP_IR_LEN 4
`define TAP_BSR_LEN 256
`define TAP_ID_LEN 32
`define TAP_IR_CAPTURE 4'h1
`define TAP_INS_EXTEST 4'h0
`define TAP_INS_SAMPLE 4'h1
`define TAP_INS_IDCODE 4'h2
`define TAP_INS_HIGHZ 4'h9
`define TAP_INS_CLAMP 4'hC
`define TAP_INS_BYPASS 4'hF
`define TAP_ID_DEFAULT 32'h0000_1001
`endif

/* File: tap_pin_sync.sv */
/*
  Samples the test port pins with the system clock. Each pin passes three
  flip-flops; a change counts once stages two and three agree.
  Assumes the test clock is much slower than clk.
*/
`timescale 1ns/1ps
`default_nettype none
module tap_pin_sync (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic tck_pin,
  input wire logic tms_pin,
  input wire logic tdi_pin,
  input wire logic trst_n_pin,
  tck_if.src ev
);
  logic [3:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d, v_q, v_d;
  always_comb begin
    s1_d = {trst_n_pin, tdi_pin, tms_pin, tck_pin};
    s2_d = s1_q;
    s3_d = s2_q;
    v_d = v_q;
    for (int i = 0; i < 4; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        v_d[i] = s3_q[i];
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_q <= 4'hF;
      s2_q <= 4'hF;
      s3_q <= 4'hF;
      v_q <= 4'hF;
    end else if (ce) begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      v_q <= v_d;
    end
  end
  assign ev.rise = ce & v_d[0] & ~v_q[0];
  assign ev.fall = ce & ~v_d[0] & v_q[0];
  assign ev.tms = v_d[1];
  assign ev.tdi = v_d[2];
  assign ev.trst_n = v_d[3];
endmodule
`default_nettype wire

/* File: tap_pkg.sv */
/*
  Types shared by the test port modules. Assumes nothing of its surroundings.
*/
package tap_pkg;
  typedef enum logic [15:0] {
    ST_RESET = 16'h0001, ST_IDLE = 16'h0002, ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008, ST_SH_DR = 16'h0010, ST_EX1_DR = 16'h0020,
    ST_PA_DR = 16'h0040, ST_EX2_DR = 16'h0080, ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR = 16'h0800,
    ST_EX1_IR = 16'h1000, ST_PA_IR = 16'h2000, ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } tap_state_t;
endpackage

/* File: tap_tester.sv */
/* Board tester model: drives test clock, mode and data in, reads data out.
   Assumes the caller keeps the test clock low between frames. */
`timescale 1ns/1ps
`default_nettype none
module tap_tester (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo_o,
  input wire logic tdo_oe_n
);
  logic tdo_line;
  // Data out has no pull-up; a released line reads as the inverse of its last level.
  assign tdo_line = tdo_oe_n ? ~tdo_o : tdo_o;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #62.5;
    o = tdo_line;
    tck = 1'b1;
    #62.5;
    tck = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
/* Self-checking bench: a tester model walks the port through each instruction.
   Assumes a 100 MHz system clock and the default 256-pin chain. */
`timescale 1ns/1ps
`default_nettype none
`include "tap_params.svh"
module tb_top;
  logic clk, resetn, tck, tms, tdi, trst_n, tdo_o, tdo_oe_n, test_mode, x;
  logic [255:0] sys_out, sys_oe_n, pin_in, pin_out, pin_oe_n, dout, pat;
  int n_fail, compares;
  tap_tester tap_tester_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o),
    .tdo_oe_n(tdo_oe_n));
  boundary_scan_tap boundary_scan_tap_inst (.clk(clk), .resetn(resetn), .ce(1'b1),
    .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n),
    .sys_out(sys_out), .sys_oe_n(sys_oe_n), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .test_mode(test_mode));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Realigns to clk so that no test pin moves on a rising clk edge.
  task automatic mv(input logic m);
    @(negedge clk);
    #2;
    tap_tester_inst.step(m, 1'b0, x);
  endtask
  // Starts and ends in idle; the wait lets the pin synchroniser catch up.
  task automatic scan(input logic ir, input logic [255:0] din, input int n);
    mv(1'b1);
    if (ir) mv(1'b1);
    mv(1'b0);
    mv(1'b0);
    dout = '0;
    for (int i = 0; i < n; i++) begin
      tap_tester_inst.step(i == n - 1, din[i], dout[i]);
    end
    mv(1'b1);
    mv(1'b0);
    repeat (8) @(negedge clk);
  endtask
  task automatic t_idcode();
    scan(1'b0, '0, 32);
    chk(dout, 256'(`TAP_ID_DEFAULT));
    chk(tdo_oe_n, 1'b1);
  endtask
  task automatic t_bypass(input logic [3:0] code);
    scan(1'b1, 256'(code), 4);
    chk(dout, 256'(`TAP_IR_CAPTURE));
    scan(1'b0, 256'hB5, 8);
    chk(dout, 256'h6A);
  endtask
  task automatic t_sample();
    pin_in = {8{32'hC0DE5A17}};
    pat = {8{32'h3C96A50F}};
    scan(1'b1, 256'(`TAP_INS_SAMPLE), 4);
    scan(1'b0, pat, 256);
    chk(dout, pin_in);
    chk(pin_out, sys_out);
  endtask
  task automatic t_extest();
    scan(1'b1, 256'(`TAP_INS_EXTEST), 4);
    chk(test_mode, 1'b1);
    for (int i = 0; i < 256; i += 2) begin
      chk(pin_out[i], pat[i]);
      chk(pin_oe_n[i], pat[i + 1]);
      chk(pin_out[i + 1], pat[i]);
      chk(pin_oe_n[i + 1], pat[i + 1]);
    end
  endtask
  task automatic t_clamp();
    scan(1'b1, 256'(`TAP_INS_CLAMP), 4);
    scan(1'b0, 256'hB5, 8);
    chk(dout, 256'h6A);
    sys_out = ~sys_out;
    repeat (12) @(negedge clk);
    chk(pin_out[2], pat[2]);
    chk(pin_oe_n[3], pat[3]);
  endtask
  task automatic t_resets();
    repeat (5) mv(1'b1);
    repeat (8) @(negedge clk);
    chk(test_mode, 1'b0);
    mv(1'b0);
    scan(1'b1, 256'(`TAP_INS_HIGHZ), 4);
    chk(pin_oe_n, '1);
    trst_n = 1'b0;
    repeat (20) @(negedge clk);
    chk(test_mode, 1'b0);
    trst_n = 1'b1;
    repeat (8) @(negedge clk);
    mv(1'b0);
    t_idcode();
  endtask
  initial begin
    resetn = 1'b0;
    trst_n = 1'b1;
    sys_out = {64{4'h6}};
    sys_oe_n = {64{4'h3}};
    pin_in = '0;
    n_fail = 0;
    compares = 0;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    repeat (6) @(negedge clk);
    #2;
    mv(1'b0);
    t_idcode();
    t_bypass(`TAP_INS_BYPASS);
    t_bypass(4'h5);
    t_sample();
    t_extest();
    t_clamp();
    t_resets();
    finish_test();
  end
  // Whole run takes about 60 us of test clocking.
  initial begin
    #300000;
    n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire

/* File: tck_if.sv */
/*
  Interface carrying synchronised test clock events from the pin sampler to the
  controller. Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface tck_if;
  logic rise;
  logic fall;
  logic tms;
  logic tdi;
  logic trst_n;
  modport src (output rise, output fall, output tms, output tdi, output trst_n);
  modport dst (input rise, input fall, input tms, input tdi, input trst_n);
endinterface
`default_nettype wire
